/* File: src/swl_pkg.sv */
package swl_pkg;

  // Default geometry: the 18-bit variant
  localparam int DATA_W_DEF    = 18;
  localparam int ADDR_W_DEF    = 10;

  // Lane widths: nibbles for the 8-bit variant, 9-bit bytes otherwise
  localparam int LANE_W_NIBBLE = 4;
  localparam int LANE_W_BYTE   = 9;

  // Variant widths the logic can serve
  localparam int VAR_W8        = 8;
  localparam int VAR_W9        = 9;
  localparam int VAR_W18       = 18;
  localparam int VAR_W36       = 36;

  // Burst word index, the low bit of the internal array address
  localparam logic BURST_FIRST  = 1'b0;
  localparam logic BURST_SECOND = 1'b1;

  // Half-cycle phase: K rise, then K-bar rise
  localparam logic PHASE_K     = 1'b0;
  localparam logic PHASE_KBAR  = 1'b1;

  // Read pipeline depth from start to last word loaded
  localparam int RD_PIPE       = 2;

  // Output launch machine for the separate output clock pair
  typedef enum logic [1:0] {
    SWL_OUT_IDLE  = 2'b00,
    SWL_OUT_ARMED = 2'b01,
    SWL_OUT_WORD0 = 2'b11,
    SWL_OUT_WORD1 = 2'b10
  } swl_out_state_type;

  // Control pins as sampled in one half-cycle
  typedef struct packed {
    logic write_port_select_n;
    logic read_port_select_n;
    logic k_rise;
  } swl_ctl_type;

  // Sampled output clock pins
  typedef struct packed {
    logic out_clk_p;
    logic out_clk_n;
  } swl_oclk_type;

endpackage

/* File: src/swl_lane_ram.sv */
`timescale 1ns/1ps
module swl_lane_ram #(
  parameter int DATA_W = 18,
  parameter int LANE_W = 9,
  parameter int LANES  = 2,
  parameter int AW     = 11
) (
  input  wire logic              clk,      // Core clock
  input  wire logic              reset_n,  // Async reset, read register only
  input  wire logic              wr_en,    // Write strobe
  input  wire logic [LANES-1:0]  wr_lane,  // Per-lane write enable, high
  input  wire logic [AW-1:0]     wr_addr,  // Write word address
  input  wire logic [DATA_W-1:0] wr_data,  // Write word
  input  wire logic [AW-1:0]     rd_addr,  // Read word address
  output logic      [DATA_W-1:0] rd_data   // Registered read word
);

  logic [DATA_W-1:0] mem_q [0:(1<<AW)-1];
  logic [DATA_W-1:0] bit_en;

  initial begin
    if (LANE_W * LANES != DATA_W) begin
      $error("swl_lane_ram: lanes do not tile the word");
    end
  end

  // Lane enables widened to bits so one process owns the array
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign bit_en[g*LANE_W +: LANE_W] = {LANE_W{wr_lane[g]}};
  end

  // Lanes with a low write enable keep their old contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= (mem_q[wr_addr] & ~bit_en) | (wr_data & bit_en);
    end
  end

  // Read returns the old word on a same-address collision
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

/* File: src/swl_write_lane_sram.sv */
`timescale 1ns/1ps
module swl_write_lane_sram
  import swl_pkg::*;
#(
  parameter int DATA_W = swl_pkg::DATA_W_DEF,
  parameter int ADDR_W = swl_pkg::ADDR_W_DEF,
  parameter int LANE_W = (DATA_W == swl_pkg::VAR_W8) ?
                         swl_pkg::LANE_W_NIBBLE : swl_pkg::LANE_W_BYTE,
  parameter int LANES  = DATA_W / LANE_W
) (
  input  wire logic              core_clk,            // Core clock
  input  wire logic              reset_n,             // Async reset, low
  output logic                   k_rise,              // High in K half
  input  wire logic              write_port_select_n, // Write start, low
  input  wire logic              read_port_select_n,  // Read start, low
  input  wire logic [ADDR_W-1:0] addr,                // Burst address
  input  wire logic [DATA_W-1:0] wdata,               // Write burst word
  input  wire logic [LANES-1:0]  lane_write_mask_n,   // Lane masks, low
  input  wire logic              out_clk_p,           // Output clock
  input  wire logic              out_clk_n,           // Output clock bar
  output logic      [DATA_W-1:0] rdata,               // Read burst word
  output logic                   rdata_oe,            // Read data driven
  output logic                   single_clock_mode    // Strap result
);

  import swl_pkg::*;

  localparam int AW = ADDR_W + 1;

  initial begin
    if (!(DATA_W == VAR_W8 || DATA_W == VAR_W9 ||
          DATA_W == VAR_W18 || DATA_W == VAR_W36)) begin
      $error("swl_write_lane_sram: DATA_W must be 8, 9, 18 or 36");
    end
    if (LANE_W * LANES != DATA_W || ADDR_W < 1) begin
      $error("swl_write_lane_sram: bad lane split or address width");
    end
  end

  // A port starts only when its select is low in a K half
  function automatic logic starts(input swl_ctl_type c, input logic sel_n);
    starts = c.k_rise && !sel_n;
  endfunction

  // Mask pins are active low; a set bit here means the lane is written
  function automatic logic [LANES-1:0] lane_enables(
    input logic [LANES-1:0] mask_n
  );
    lane_enables = ~mask_n;
  endfunction

  // Half-cycle phase and input registers
  logic              phase_q;
  logic              phase_d;
  swl_ctl_type       ctl_q;
  swl_ctl_type       ctl_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [LANES-1:0]  mask_n_q;

  // Write path
  logic              wr_start;
  logic              wr_second_q;
  logic [ADDR_W-1:0] waddr_q;
  logic              wr_active;
  logic [LANES-1:0]  wr_lane;
  logic              wr_en;
  logic [AW-1:0]     wr_addr;

  // Read path
  logic              rd_start;
  logic [ADDR_W-1:0] raddr_q;
  logic [RD_PIPE-1:0] rd_v_q;
  logic [RD_PIPE-1:0] rd_v_d;
  logic [AW-1:0]     rd_addr;
  logic [DATA_W-1:0] rd_word;

  // Strap capture
  logic              strap_done_q;
  logic              single_q;
  logic              strap_now;
  logic              single_d;

  // Output stage
  swl_oclk_type      oclk_q;
  swl_oclk_type      oclk_prev_q;
  logic              cp_rise;
  logic              cn_rise;
  swl_out_state_type out_state_q;
  swl_out_state_type out_state_d;
  logic [DATA_W-1:0] word0_q;
  logic [DATA_W-1:0] word1_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              oe_q;
  logic              oe_d;
  logic              load_word;

  assign phase_d = ~phase_q;
  assign k_rise  = (phase_q == PHASE_K);
  assign ctl_d   = '{write_port_select_n: write_port_select_n,
                     read_port_select_n:  read_port_select_n,
                     k_rise:              k_rise};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q  <= PHASE_K;
      ctl_q    <= '{write_port_select_n: 1'b1,
                    read_port_select_n:  1'b1,
                    k_rise:              1'b0};
      addr_q   <= '0;
      wdata_q  <= '0;
      mask_n_q <= '1;
    end else begin
      phase_q  <= phase_d;
      ctl_q    <= ctl_d;
      addr_q   <= addr;
      wdata_q  <= wdata;
      mask_n_q <= lane_write_mask_n;
    end
  end

  // start seen only in K half
  assign wr_start = starts(ctl_q, ctl_q.write_port_select_n);
  assign rd_start = starts(ctl_q, ctl_q.read_port_select_n);

  assign wr_addr = wr_start ? {ctl_q.k_rise ? addr_q : waddr_q, BURST_FIRST}
                            : {waddr_q, BURST_SECOND};

  // masks of the current word only
  assign wr_active = wr_start || wr_second_q;

  assign wr_lane = lane_enables(mask_n_q);

  assign wr_en = wr_active && (|wr_lane);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_second_q <= 1'b0;
      waddr_q     <= '0;
    end else begin
      wr_second_q <= wr_start;
      if (wr_start) begin
        waddr_q <= addr_q;
      end
    end
  end

  assign rd_addr = rd_start ? {addr_q, BURST_FIRST}
                            : {raddr_q, BURST_SECOND};

  assign rd_v_d = {rd_v_q[0], rd_start};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      raddr_q <= '0;
      rd_v_q  <= '0;
    end else begin
      rd_v_q <= rd_v_d;
      if (rd_start) begin
        raddr_q <= addr_q;
      end
    end
  end

  swl_lane_ram #(
    .DATA_W (DATA_W),
    .LANE_W (LANE_W),
    .LANES  (LANES),
    .AW     (AW)
  ) u_ram (
    .clk     (core_clk),
    .reset_n (reset_n),
    .wr_en   (wr_en),
    .wr_lane (wr_lane),
    .wr_addr (wr_addr),
    .wr_data (wdata_q),
    .rd_addr (rd_addr),
    .rd_data (rd_word)
  );

  // both output clocks high at release
  assign strap_now = !strap_done_q;
  assign single_d  = strap_now ? (out_clk_p && out_clk_n) : single_q;

  // Strap is caught by the first clock after release, not by the reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_q <= 1'b0;
      single_q     <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      single_q     <= single_d;
    end
  end

  assign single_clock_mode = single_q;

  // Output clock pins are synchronous, so one stage and a history suffice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oclk_q      <= '{out_clk_p: 1'b1, out_clk_n: 1'b1};
      oclk_prev_q <= '{out_clk_p: 1'b1, out_clk_n: 1'b1};
    end else begin
      oclk_q      <= '{out_clk_p: out_clk_p, out_clk_n: out_clk_n};
      oclk_prev_q <= oclk_q;
    end
  end

  assign cp_rise   = oclk_q.out_clk_p && !oclk_prev_q.out_clk_p;
  assign cn_rise   = oclk_q.out_clk_n && !oclk_prev_q.out_clk_n;
  assign load_word = |rd_v_q;

  // Separate output clocks: one burst in flight; a read started before
  // the previous burst has left is dropped, but one whose second word lands back in SWL_OUT_IDLE goes out with a stale word0_q
  always_comb begin
    out_state_d = out_state_q;
    case (out_state_q)
      SWL_OUT_IDLE: begin
        if (!single_q && rd_v_q[RD_PIPE-1]) begin
          out_state_d = SWL_OUT_ARMED;
        end
      end
      SWL_OUT_ARMED: begin
        if (cn_rise) begin
          out_state_d = SWL_OUT_WORD0;
        end
      end
      SWL_OUT_WORD0: begin
        if (cp_rise) begin
          out_state_d = SWL_OUT_WORD1;
        end
      end
      SWL_OUT_WORD1: begin
        if (cp_rise || cn_rise) begin
          out_state_d = SWL_OUT_IDLE;
        end
      end
      default: begin
        out_state_d = SWL_OUT_IDLE;
      end
    endcase
  end

  // output clock pair or input pair
  // input pair: first word t+1 K-bar, second t+2 K; output pair: on out_clk_n, then out_clk_p rise
  always_comb begin
    rdata_d = rdata_q;
    oe_d    = 1'b0;
    if (single_q) begin
      oe_d = load_word;
      if (load_word) begin
        rdata_d = rd_word;
      end
    end else begin
      case (out_state_d)
        SWL_OUT_WORD0: begin
          rdata_d = word0_q;
          oe_d    = 1'b1;
        end
        SWL_OUT_WORD1: begin
          rdata_d = word1_q;
          oe_d    = 1'b1;
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_state_q <= SWL_OUT_IDLE;
      word0_q     <= '0;
      word1_q     <= '0;
      rdata_q     <= '0;
      oe_q        <= 1'b0;
    end else begin
      out_state_q <= out_state_d;
      rdata_q     <= rdata_d;
      oe_q        <= oe_d;
      if (out_state_q == SWL_OUT_IDLE && rd_v_q[0]) begin
        word0_q <= rd_word;
      end
      if (out_state_q == SWL_OUT_IDLE && rd_v_q[RD_PIPE-1]) begin
        word1_q <= rd_word;
      end
    end
  end

  assign rdata    = rdata_q;
  assign rdata_oe = oe_q;

endmodule

/* File: testbench/swl_checker_properties.sv */
`timescale 1ns/1ps
module swl_checker (
  input wire logic core_clk,           // Clock
  input wire logic reset_n,            // Reset, low
  input wire logic k_rise,             // K half
  input wire logic read_port_select_n, // Read start, low
  input wire logic out_clk_p,          // Output clock
  input wire logic out_clk_n,          // Output clock bar
  input wire logic rdata_oe,           // Read drive
  input wire logic single_clock_mode   // Strap
);
  logic rd_start;
  assign rd_start = k_rise & ~read_port_select_n & single_clock_mode;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_k_alternates: assert property (
    $past(reset_n) |-> k_rise != $past(k_rise))
    else $error("k phase did not alternate");
  a_k_first_half: assert property (
    $rose(reset_n) |-> k_rise)
    else $error("first cycle is not a K half");
  a_strap_hold: assert property (
    $past(reset_n, 2) |-> $stable(single_clock_mode))
    else $error("clock mode changed in operation");
  a_strap_cause: assert property (
    $rose(single_clock_mode) |-> $past(out_clk_p & out_clk_n))
    else $error("single mode without both output clocks high");
  a_read_latency: assert property (
    rd_start |-> ##3 rdata_oe ##1 rdata_oe)
    else $error("read words not driven at t+1 and t+2");
  a_oe_cause: assert property (
    single_clock_mode && $rose(rdata_oe) |-> $past(rd_start, 3))
    else $error("read drive without a read start");
  a_oe_drop: assert property (
    rd_start ##2 !rd_start |-> ##3 !rdata_oe)
    else $error("read drive held after burst");
  a_oe_idle_off: assert property (
    single_clock_mode && !$past(rd_start, 3) && !$past(rd_start, 4)
    |-> !rdata_oe)
    else $error("read outputs driven while deselected");
endmodule

bind swl_write_lane_sram swl_checker swl_checker_inst (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .k_rise(k_rise),
  .read_port_select_n(read_port_select_n),
  .out_clk_p(out_clk_p),
  .out_clk_n(out_clk_n),
  .rdata_oe(rdata_oe),
  .single_clock_mode(single_clock_mode)
);

/* File: testbench/swl_ctl_model.sv */
`timescale 1ns/1ps
module swl_ctl_model
  import swl_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int LANES  = 2
) (
  input  wire logic              core_clk,            // Clock
  input  wire logic              k_rise,              // K half
  output logic                   write_port_select_n, // Write start
  output logic                   read_port_select_n,  // Read start
  output logic      [ADDR_W-1:0] addr,                // Address
  output logic      [DATA_W-1:0] wdata,               // Write word
  output logic      [LANES-1:0]  lane_write_mask_n    // Lane masks
);
  initial begin
    write_port_select_n = 1'b1;
    read_port_select_n  = 1'b1;
    addr                = '0;
    wdata               = '0;
    lane_write_mask_n   = '1;
  end

  // Old k_rise low at an edge means the next cycle is a K half
  task automatic to_k_half();
    do @(posedge core_clk);
    while (k_rise !== 1'b0);
  endtask

  // start at K, masks ride with words
  task automatic write_burst(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d0, d1,
                             input logic [LANES-1:0]  m0, m1);
    to_k_half();
    write_port_select_n <= 1'b0;
    addr                <= a;
    wdata               <= d0;
    lane_write_mask_n   <= m0;
    @(posedge core_clk);
    write_port_select_n <= 1'b1;
    addr                <= ~a;
    wdata               <= d1;
    lane_write_mask_n   <= m1;
  endtask

  // Released lines show the inverse, not a stale word
  task automatic idle();
    @(posedge core_clk);
    wdata             <= ~wdata;
    lane_write_mask_n <= ~lane_write_mask_n;
  endtask

  task automatic read_start(input logic [ADDR_W-1:0] a);
    to_k_half();
    read_port_select_n <= 1'b0;
    addr               <= a;
    @(posedge core_clk);
    read_port_select_n <= 1'b1;
    addr               <= ~a;
  endtask
endmodule

/* File: testbench/swl_write_lane_sram_tb.sv */
`timescale 1ns/1ps
module swl_write_lane_sram_tb;
  import swl_pkg::*;
  localparam int W  = 18;
  localparam int AW = 10;
  logic          core_clk;
  logic          reset_n;
  logic          k_rise;
  logic          wps_n;
  logic          rps_n;
  logic [AW-1:0] addr;
  logic [W-1:0]  wdata;
  logic [1:0]    mask_n;
  logic          out_clk_p;
  logic          out_clk_n;
  logic [W-1:0]  rdata;
  logic          rdata_oe;
  logic          scm;
  logic [W-1:0]  rm [16];
  logic [AW-1:0] at [8];
  int            n_fail;
  int            samples_checked;
  int            cyc;

  swl_write_lane_sram #(.DATA_W(W), .ADDR_W(AW)) swl_write_lane_sram_inst (
    .core_clk(core_clk), .reset_n(reset_n), .k_rise(k_rise),
    .write_port_select_n(wps_n), .read_port_select_n(rps_n),
    .addr(addr), .wdata(wdata), .lane_write_mask_n(mask_n),
    .out_clk_p(out_clk_p), .out_clk_n(out_clk_n), .rdata(rdata),
    .rdata_oe(rdata_oe), .single_clock_mode(scm));

  swl_ctl_model #(.ADDR_W(AW), .DATA_W(W)) swl_ctl_model_inst (
    .core_clk(core_clk), .k_rise(k_rise), .write_port_select_n(wps_n),
    .read_port_select_n(rps_n), .addr(addr), .wdata(wdata),
    .lane_write_mask_n(mask_n));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Lanes with a high mask keep the old bits
  function automatic logic [W-1:0] merge(logic [W-1:0] o, n,
                                         logic [1:0] m);
    merge = o;
    for (int l = 0; l < 2; l++)
      if (!m[l])
        merge[l*LANE_W_BYTE +: LANE_W_BYTE] = n[l*LANE_W_BYTE +: LANE_W_BYTE];
  endfunction

  task automatic wr(input int s, input logic [1:0] m0, m1);
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    d0 = W'($urandom);
    d1 = W'($urandom);
    swl_ctl_model_inst.write_burst(at[s], d0, d1, m0, m1);
    rm[2*s]   = merge(rm[2*s], d0, m0);
    rm[2*s+1] = merge(rm[2*s+1], d1, m1);
  endtask

  task automatic rd(input int s);
    swl_ctl_model_inst.read_start(at[s]);
    repeat (2) @(posedge core_clk);
    #1;
    chk("oe word0", {17'h0, rdata_oe}, 18'h1);
    chk("word0", rdata, rm[2*s]);
    @(posedge core_clk);
    #1;
    chk("oe word1", {17'h0, rdata_oe}, 18'h1);
    chk("word1", rdata, rm[2*s+1]);
    @(posedge core_clk);
    #1;
    chk("oe after", {17'h0, rdata_oe}, 18'h0);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    void'($urandom(96167));
    reset_n   = 1'b0;
    // output clocks held high: single mode
    out_clk_p = 1'b1;
    out_clk_n = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("oe in reset", {17'h0, rdata_oe}, 18'h0);
    @(posedge core_clk);
    reset_n <= 1'b1;
    // Lowest and highest addresses sit among the slots
    at[0] = '0;
    at[7] = '1;
    for (int s = 1; s < 7; s++)
      at[s] = {7'($urandom), 3'(s)};
    for (int s = 0; s < 8; s++)
      wr(s, 2'h0, 2'h0);
    for (int i = 0; i < 16; i++)
      wr(i % 8, i[1:0], i[3:2]);
    for (int i = 0; i < 24; i++)
      wr($urandom % 8, 2'($urandom), 2'($urandom));
    swl_ctl_model_inst.idle();
    repeat (3) @(posedge core_clk);
    #1;
    chk("mode", {17'h0, scm}, 18'h1);
    chk("oe idle", {17'h0, rdata_oe}, 18'h0);
    for (int s = 0; s < 8; s++)
      rd(s);
    test_done();
  end
endmodule
